// >>> rpf_pkg.sv
// How it works
// - Frame opens with start byte, then 16-bit length of bytes from the type byte up to the checksum.
// - Last byte is 0xFF minus low byte of sum from offset 3 onward.
// - Options setting zero gives standard receive frame, type 0x90.
// - Options bit 1 set gives explicit receive frame, type 0x91.
// - Sender 64-bit address at offset 4, then 0xFFFE field at 12.
// - Standard frame: options byte at 14, payload from 15 to checksum.
// - Options bit 0 acknowledged, bit 1 broadcast, bits 2 to 5 reserved.
// - Options bits 7:6 carry delivery method code.
// - All applicable option flags are ORed into one byte.
// - Explicit frame: source endpoint at 14, destination endpoint at 15.
// - Explicit frame: cluster id at 16, profile id at 18.
// - Explicit frame: options at 20, payload from 21 to checksum.
package rpf_pkg;
  // ********************************
  // Frame constants
  // ********************************
  localparam logic [7:0]  RPF_START     = 8'h7e;
  localparam logic [7:0]  RPF_TYPE_STD  = 8'h90;
  localparam logic [7:0]  RPF_TYPE_EXP  = 8'h91;
  localparam logic [15:0] RPF_UNUSED    = 16'hfffe;
  localparam logic [7:0]  RPF_CSUM_BASE = 8'hff;
  localparam int          RPF_EXP_BIT   = 1;
  localparam logic [7:0]  RPF_OPT_ACK   = 8'h01;
  localparam logic [7:0]  RPF_OPT_BCAST = 8'h02;
  localparam logic [4:0]  RPF_HDR_STD   = 5'd15;
  localparam logic [4:0]  RPF_HDR_EXP   = 5'd21;
  localparam logic [4:0]  RPF_HDR_FIRST = 5'd3;
  localparam logic [15:0] RPF_LEN_ADJ   = 16'd3;
  localparam logic [15:0] RPF_MAX_PAY   = 16'hffea;

  typedef struct packed {
    logic [63:0] src_addr;
    logic [7:0]  src_ep;
    logic [7:0]  dst_ep;
    logic [15:0] cluster;
    logic [15:0] profile;
    logic        acked;
    logic        bcast;
    logic [1:0]  method;
    logic [15:0] pay_len;
  } rpf_hdr_t;

  typedef enum logic [2:0] {
    RPF_IDLE = 3'b000,
    RPF_HEAD = 3'b001,
    RPF_PAY  = 3'b011,
    RPF_SUM  = 3'b010
  } rpf_state_t;
endpackage

// >>> rpf_hdr_byte.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Header byte selector
// ********************************
module rpf_hdr_byte
  import rpf_pkg::*;
(
  input  wire logic       explicit_fmt,
  input  wire logic [4:0] idx,
  input  wire rpf_hdr_t   hdr,
  input  wire logic [7:0] opts,
  input  wire logic [15:0] len,
  output logic [7:0]      hbyte
);
  // Byte at each fixed offset, high byte first
  always_comb begin
    hbyte = 8'h00;
    case (idx)
      5'd0:  hbyte = RPF_START;
      5'd1:  hbyte = len[15:8];
      5'd2:  hbyte = len[7:0];
      5'd3:  hbyte = explicit_fmt ? RPF_TYPE_EXP : RPF_TYPE_STD;
      5'd4:  hbyte = hdr.src_addr[63:56];
      5'd5:  hbyte = hdr.src_addr[55:48];
      5'd6:  hbyte = hdr.src_addr[47:40];
      5'd7:  hbyte = hdr.src_addr[39:32];
      5'd8:  hbyte = hdr.src_addr[31:24];
      5'd9:  hbyte = hdr.src_addr[23:16];
      5'd10: hbyte = hdr.src_addr[15:8];
      5'd11: hbyte = hdr.src_addr[7:0];
      5'd12: hbyte = RPF_UNUSED[15:8];
      5'd13: hbyte = RPF_UNUSED[7:0];
      5'd14: hbyte = explicit_fmt ? hdr.src_ep : opts;
      5'd15: hbyte = hdr.dst_ep;
      5'd16: hbyte = hdr.cluster[15:8];
      5'd17: hbyte = hdr.cluster[7:0];
      5'd18: hbyte = hdr.profile[15:8];
      5'd19: hbyte = hdr.profile[7:0];
      5'd20: hbyte = opts;
      default: hbyte = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

// >>> rpf_emitter.sv
`timescale 1ns/1ps
`default_nettype none
module rpf_emitter
  import rpf_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [7:0] api_output_options,
  input  wire logic       pkt_valid,
  input  wire rpf_hdr_t   pkt_hdr,
  output logic            pkt_ready,
  input  wire logic       pay_valid,
  input  wire logic [7:0] pay_data,
  output logic            pay_ready,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  output logic            tx_last,
  input  wire logic       tx_ready
);
  // ********************************
  // State
  // ********************************
  rpf_state_t  state;
  rpf_hdr_t    hdr;
  logic        explicit_fmt;
  logic [4:0]  idx;
  logic [15:0] pay_cnt;
  logic [7:0]  sum;
  logic [7:0]  opts;
  logic [15:0] len;
  logic [7:0]  hbyte;
  logic [4:0]  hdr_end;
  logic        out_free;
  logic        take_pay;

  // Output register empty or draining this cycle
  assign out_free = !tx_valid || tx_ready;
  assign hdr_end  = explicit_fmt ? RPF_HDR_EXP : RPF_HDR_STD;
  // Length counts type byte through last payload byte
  assign len      = {11'h000, hdr_end} - RPF_LEN_ADJ + hdr.pay_len;
  // Flags combined by OR; reserved bits stay zero
  assign opts     = (hdr.acked ? RPF_OPT_ACK : 8'h00) | (hdr.bcast ? RPF_OPT_BCAST : 8'h00) |
                    {hdr.method, 6'h00};
  assign take_pay = (state == RPF_PAY) && out_free && pay_valid && (pay_cnt != 16'h0000);

  rpf_hdr_byte u_hdr (
    .explicit_fmt (explicit_fmt),
    .idx          (idx),
    .hdr          (hdr),
    .opts         (opts),
    .len          (len),
    .hbyte        (hbyte)
  );

  // ********************************
  // Sequencer
  // ********************************
  // Format latched per packet so a mid-frame options change cannot tear a frame
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state        <= RPF_IDLE;
      hdr          <= '0;
      explicit_fmt <= 1'b0;
      idx          <= 5'd0;
      pay_cnt      <= 16'h0000;
    end else begin
      case (state)
        RPF_IDLE: begin
          if (pkt_valid) begin
            hdr          <= pkt_hdr;
            // Payload clipped so the length field cannot wrap
            if (pkt_hdr.pay_len > RPF_MAX_PAY) begin
              hdr.pay_len <= RPF_MAX_PAY;
            end
            explicit_fmt <= api_output_options[RPF_EXP_BIT];
            idx          <= 5'd0;
            state        <= RPF_HEAD;
          end
        end
        RPF_HEAD: begin
          if (out_free) begin
            if (idx == hdr_end - 5'd1) begin
              pay_cnt <= hdr.pay_len;
              state   <= RPF_PAY;
            end
            idx <= idx + 5'd1;
          end
        end
        RPF_PAY: begin
          if (pay_cnt == 16'h0000) begin
            state <= RPF_SUM;
          end else if (take_pay) begin
            pay_cnt <= pay_cnt - 16'h0001;
          end
        end
        RPF_SUM: begin
          if (out_free) begin
            state <= RPF_IDLE;
          end
        end
        default: state <= RPF_IDLE;
      endcase
    end
  end

  // Handshake outputs come from flip-flops
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pkt_ready <= 1'b0;
      pay_ready <= 1'b0;
    end else begin
      // Acknowledge pulse set on the capture edge itself; state leaves idle so it lasts one cycle
      pkt_ready <= (state == RPF_IDLE) && pkt_valid;
      pay_ready <= take_pay;
    end
  end

  // ********************************
  // Output byte and checksum
  // ********************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
      sum      <= 8'h00;
    end else begin
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
      end
      if (state == RPF_HEAD && out_free) begin
        tx_valid <= 1'b1;
        tx_data  <= hbyte;
        if (idx == RPF_HDR_FIRST) begin
          sum <= hbyte;
        end else if (idx > RPF_HDR_FIRST) begin
          sum <= sum + hbyte;
        end
      end else if (take_pay) begin
        tx_valid <= 1'b1;
        tx_data  <= pay_data;
        sum      <= sum + pay_data;
      end else if (state == RPF_SUM && out_free) begin
        tx_valid <= 1'b1;
        tx_data  <= RPF_CSUM_BASE - sum;
        tx_last  <= 1'b1;
      end
    end
  end

  // ********************************
  // Checks
  // ********************************
  start_byte_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd0 && out_free) |=> (tx_data == RPF_START))
    else $error("start delimiter wrong");
  type_code_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd3 && out_free) |=>
    (tx_data == (explicit_fmt ? 8'h91 : 8'h90)))
    else $error("frame type wrong");
  fmt_latch_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_IDLE && pkt_valid) |=> (explicit_fmt == $past(api_output_options[1])))
    else $error("format not taken from options");
  unused_field_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd12 && out_free) |=> (tx_data == 8'hff))
    else $error("unused field high byte wrong");
  opt_reserved_a: assert property (@(posedge mclk) disable iff (reset)
    opts[5:2] == 4'h0)
    else $error("reserved option bits set");
  opt_method_a: assert property (@(posedge mclk) disable iff (reset)
    opts[7:6] == hdr.method && opts[0] == hdr.acked && opts[1] == hdr.bcast)
    else $error("option byte mismatch");
  length_calc_a: assert property (@(posedge mclk) disable iff (reset)
    len == (explicit_fmt ? 16'd18 : 16'd12) + hdr.pay_len)
    else $error("length field wrong");
  checksum_out_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_SUM && out_free) |=> (tx_last && tx_valid && (tx_data + $past(sum) == 8'hff)))
    else $error("checksum byte wrong");
  pay_start_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && out_free && idx == hdr_end - 5'd1) |=> (state == RPF_PAY))
    else $error("payload offset wrong");

  // ********************************
  // Field placement and stream checks
  // ********************************
  // Header fields are stable for the whole frame, so they are compared one edge after emission
  len_high_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd1 && out_free) |=> (tx_data == len[15:8]))
    else $error("length high byte wrong");
  len_low_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd2 && out_free) |=> (tx_data == len[7:0]))
    else $error("length low byte wrong");
  addr_high_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd4 && out_free) |=> (tx_data == hdr.src_addr[63:56]))
    else $error("address first byte wrong");
  addr_low_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd11 && out_free) |=> (tx_data == hdr.src_addr[7:0]))
    else $error("address last byte wrong");
  unused_low_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd13 && out_free) |=> (tx_data == 8'hfe))
    else $error("unused field low byte wrong");
  std_opts_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd14 && out_free && !explicit_fmt) |=> (tx_data == opts))
    else $error("standard options byte wrong");
  src_ep_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd14 && out_free && explicit_fmt) |=> (tx_data == hdr.src_ep))
    else $error("source endpoint wrong");
  dst_ep_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd15 && out_free) |=> (tx_data == hdr.dst_ep))
    else $error("destination endpoint wrong");
  cluster_id_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd16 && out_free) |=> (tx_data == hdr.cluster[15:8]))
    else $error("cluster id wrong");
  profile_id_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd18 && out_free) |=> (tx_data == hdr.profile[15:8]))
    else $error("profile id wrong");
  exp_opts_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_HEAD && idx == 5'd20 && out_free) |=> (tx_data == opts))
    else $error("explicit options byte wrong");
  // Payload bytes pass through untouched; a stalled byte must not change under the sink
  pay_copy_a: assert property (@(posedge mclk) disable iff (reset)
    take_pay |=> (tx_valid && tx_data == $past(pay_data)))
    else $error("payload byte not copied");
  tx_hold_a: assert property (@(posedge mclk) disable iff (reset)
    (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data) && $stable(tx_last)))
    else $error("output byte changed while stalled");
  hdr_ack_a: assert property (@(posedge mclk) disable iff (reset)
    (state == RPF_IDLE && pkt_valid) |=> (pkt_ready && state == RPF_HEAD))
    else $error("packet not acknowledged");
endmodule
`default_nettype wire

// >>> rpf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Host sink on the serial side
// ********************************
module rpf_host_model
  import rpf_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       stall_en,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [7:0] rx_q[$];
  logic [7:0] acc;
  int         frames = 0;
  logic       sum_ok = 1'b0;

  // Random back-pressure, so the emitter must hold each byte while stalled
  always @(negedge mclk) tx_ready <= !reset && (!stall_en || ($urandom % 2) == 1);

  // Collect bytes; at the last one the type byte through checksum must total 0xff
  always @(posedge mclk) begin
    if (!reset && tx_valid && tx_ready) begin
      rx_q.push_back(tx_data);
      if (tx_last) begin
        acc = 8'h00;
        for (int i = 3; i < rx_q.size(); i++) acc += rx_q[i];
        sum_ok = (acc == 8'hff);
        frames++;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rx_packet_frame_emitter_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rx_packet_frame_emitter_bench
  import rpf_pkg::*;
;
  logic       mclk = 1'b0, reset = 1'b1, pkt_valid = 1'b0, pay_valid = 1'b0, stall_en = 1'b0;
  logic [7:0] api_output_options = 8'h00, pay_data = 8'h00, tx_data;
  rpf_hdr_t   pkt_hdr = '0;
  logic       pkt_ready, pay_ready, tx_valid, tx_last, tx_ready;
  int         bad_count = 0, checks_done = 0;
  logic [7:0] exp_q[$], pay_q[$];

  initial forever #4 mclk = ~mclk;

  rpf_emitter dut (.mclk(mclk), .reset(reset), .api_output_options(api_output_options),
    .pkt_valid(pkt_valid), .pkt_hdr(pkt_hdr), .pkt_ready(pkt_ready), .pay_valid(pay_valid),
    .pay_data(pay_data), .pay_ready(pay_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));
  rpf_host_model host (.mclk(mclk), .reset(reset), .stall_en(stall_en), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

  // ********************************
  // Checking helpers
  // ********************************
  task automatic stop_test();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // Bounded wait at falling edges: 0 header ack, 1 byte ack, 2 frame count reached
  task automatic await(input int which, input int target);
    for (int k = 0; k < 3000; k++) begin
      @(negedge mclk);
      if (which == 0 ? pkt_ready === 1'b1 : which == 1 ? pay_ready === 1'b1 : host.frames == target)
        return;
    end
    bad_count++;
    $display("BAD timeout expected 1 seen 0");
    stop_test();
  endtask

  // Reference frame built from the field layout with plain queues
  task automatic build(input logic [7:0] ao, input rpf_hdr_t h);
    logic [7:0] b[$];
    logic [7:0] s;
    s = 8'hff;
    b.push_back(ao[1] ? 8'h91 : 8'h90);
    for (int i = 7; i >= 0; i--) b.push_back(h.src_addr[i*8 +: 8]);
    b = {b, 8'hff, 8'hfe};
    if (ao[1])
      b = {b, h.src_ep, h.dst_ep, h.cluster[15:8], h.cluster[7:0], h.profile[15:8], h.profile[7:0]};
    b.push_back({h.method, 4'h0, h.bcast, h.acked});
    b = {b, pay_q};
    foreach (b[i]) s -= b[i];
    exp_q = {8'h7e, 8'(b.size() >> 8), 8'(b.size()), b, s};
  endtask

  // ********************************
  // One packet through the emitter
  // ********************************
  task automatic run_frame(input int f);
    rpf_hdr_t h;
    int       n;
    n = (f == 3) ? 0 : $urandom % 12;
    h = '0;
    h.src_addr = {$urandom, $urandom};
    {h.src_ep, h.dst_ep, h.cluster} = $urandom;
    h.profile = 16'($urandom);
    h.method = 2'(f);
    h.acked = f[2];
    h.bcast = f[3] ^ f[0]; // unicast and broadcast senders both appear
    h.pay_len = 16'(n);
    pay_q = {};
    repeat (n) pay_q.push_back(8'($urandom));
    // Zero, bit 1 alone and bit 1 with a neighbour set
    api_output_options = (f % 3 == 0) ? 8'h00 : (f % 3 == 1) ? 8'h02 : 8'h06;
    stall_en = f[0];
    build(api_output_options, h);
    pkt_hdr = h;
    pkt_valid = 1'b1;
    await(0, 0);
    // Header stays up through the edge that samples the acknowledge
    @(negedge mclk);
    pkt_valid = 1'b0;
    // One byte at a time, with a gap so no byte is taken twice
    foreach (pay_q[i]) begin
      pay_data = pay_q[i];
      pay_valid = 1'b1;
      await(1, 0);
      pay_valid = 1'b0;
      @(negedge mclk);
    end
    await(2, f + 1);
    chk("frame_len", 8'(exp_q.size()), 8'(host.rx_q.size()));
    foreach (exp_q[i]) chk("frame_byte", exp_q[i], host.rx_q[i]);
    chk("host_sum", 8'h01, {7'h00, host.sum_ok});
    host.rx_q = {};
  endtask

  initial begin
    void'($urandom(32'h87d0));
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    for (int f = 0; f < 12; f++) run_frame(f);
    stop_test();
  end
endmodule
`default_nettype wire
